// >>> include/cpu_ctrl_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CPU_CTRL_CFG_SVH
`define CPU_CTRL_CFG_SVH
`define CFG_OFS_PTR0_LO 8'h82
`define CFG_OFS_PTR0_HI 8'h83
`define CFG_OFS_PTR1_LO 8'h84
`define CFG_OFS_PTR1_HI 8'h85
`define CFG_OFS_PTR_SEL 8'h86
`define CFG_OFS_WAIT 8'h92
`define CFG_OFS_MODE 8'h9D
`define CFG_OFS_RST_CTRL 8'h9E
`define CFG_SEL_BIT 0
`define CFG_TSL_BIT 5
`define CFG_STEP_LO_BIT 6
`define CFG_STEP_HI_BIT 7
`define CFG_PAGE_SRC_BIT 3
`define CFG_EXT_STACK_BIT 2
`define CFG_SDROP_EN_BIT 0
`define CFG_WDT_EN_BIT 1
`define CFG_WDT_RST_EN_BIT 2
`define CFG_WAIT_RST 4'h7
`define CFG_PC_VECTOR 20'h0F000
`define CFG_SYNC_INIT 4'h2
`define CFG_CLK_PERIOD_NS 4
`define CFG_PIN_GLITCH_NS 5000
`define CFG_PIN_GLITCH_CYC \
    ((`CFG_PIN_GLITCH_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`endif

// >>> include/cpu_ctrl_pkg.sv
// Shared types of the core control block
package cpu_ctrl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_COUNT = 2'b01
    } ws_state_t;
endpackage : cpu_ctrl_pkg

// >>> core/reset_ctrl.sv
// Reset source synchronisers, pin glitch filter and reset combiner
`timescale 1ns/1ps
`include "cpu_ctrl_cfg.svh"
module reset_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Reset sources
    input wire logic por_i,
    input wire logic external_reset_pin_n_i,
    input wire logic low_voltage_reset_i,
    input wire logic supply_drop_detector_i,
    input wire logic supply_drop_en_i,
    input wire logic watchdog_reset_i,
    // Combined reset and pin pull-down
    output logic core_rst_o,
    output logic pin_drive_o
);
    import cpu_ctrl_pkg::*;
    // Bit 0 power, 1 pin, 2 low voltage, 3 supply drop
    logic [3:0] s1, s2, s3, stable, next_stable;
    logic [10:0] low_cnt, next_low_cnt;
    logic pin_rst, next_pin_rst, next_core_rst, next_pin_drive;

    always_comb begin
        next_stable = stable;
        for (int i = 0; i < 4; i++) begin
            if (s2[i] == s3[i]) begin
                next_stable[i] = s3[i];
            end
        end
        // [RULE4] Pin low filter
        if (stable[1]) begin
            next_low_cnt = 11'h000;
        end else if (low_cnt == 11'(`CFG_PIN_GLITCH_CYC)) begin
            next_low_cnt = low_cnt;
        end else begin
            next_low_cnt = low_cnt + 11'h001;
        end
        next_pin_rst = (next_low_cnt == 11'(`CFG_PIN_GLITCH_CYC));
        // [RULE1] [RULE2] Source combination
        next_core_rst = rst_i | stable[0] | pin_rst | stable[2]
            | (stable[3] & supply_drop_en_i) | watchdog_reset_i;
        // [RULE3] Stretch via pin
        next_pin_drive = stable[2];
    end

    // [RULE23] Clocked release
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1 <= `CFG_SYNC_INIT;
            s2 <= `CFG_SYNC_INIT;
            s3 <= `CFG_SYNC_INIT;
            stable <= `CFG_SYNC_INIT;
            low_cnt <= 11'h000;
            pin_rst <= 1'b0;
            core_rst_o <= 1'b1;
            pin_drive_o <= 1'b0;
        end else begin
            s1 <= {supply_drop_detector_i, low_voltage_reset_i,
                   external_reset_pin_n_i, por_i};
            s2 <= s1;
            s3 <= s2;
            stable <= next_stable;
            low_cnt <= next_low_cnt;
            pin_rst <= next_pin_rst;
            core_rst_o <= next_core_rst;
            pin_drive_o <= next_pin_drive;
        end
    end
endmodule : reset_ctrl

// >>> core/flash_wait.sv
// Flash fetch wait-state counter
`timescale 1ns/1ps
module flash_wait (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Fetch handshake
    input wire logic fetch_req_i,
    input wire logic [3:0] wait_states_i,
    output logic fetch_stall_o,
    output logic fetch_done_o
);
    import cpu_ctrl_pkg::*;
    ws_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic next_done;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_done = 1'b0;
        case (state)
            WS_IDLE: begin
                if (fetch_req_i) begin
                    next_state = WS_COUNT;
                    next_cnt = wait_states_i;
                end
            end
            WS_COUNT: begin
                // [RULE15] Field plus one cycles
                if (cnt == 4'h0) begin
                    next_done = 1'b1;
                    next_state = WS_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: next_state = WS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= WS_IDLE;
            cnt <= 4'h0;
            fetch_done_o <= 1'b0;
            fetch_stall_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            fetch_done_o <= next_done;
            fetch_stall_o <= (next_state == WS_COUNT);
        end
    end
endmodule : flash_wait

// >>> core/cpu_core_ctrl.sv
// Core control: reset, address mode, flash wait states, data pointers
`timescale 1ns/1ps
`include "cpu_ctrl_cfg.svh"
// Overview of operation
// [RULE1] Any reset source resets all registers
// [RULE2] Supply-drop reset off until software enables
// [RULE3] Low-voltage reset pulls reset pin low
// [RULE4] Pin lows under 5 us ignored
// [RULE5] Outside holds pin low at least 50 us
// [RULE6] Watchdog and its reset off after reset
// [RULE7] Program counter starts at 0x0F000
// [RULE8] Internal oscillator selected after reset
// [RULE9] Oscillator runs except stop and sleep
// [RULE10] Mode bits: 00 narrow, 1x wide
// [RULE11] Data addresses always sixteen bits
// [RULE12] Stack indicator: internal or extended stack
// [RULE13] Page source bit picks port latch or register
// [RULE14] Mode register resets zero, timed-access writes
// [RULE15] Fetch takes wait field plus one cycles
// [RULE16] Wait field resets to seven
// [RULE17] Software matches wait states to clock
// [RULE18] Select bit picks pointer, reads back
// [RULE19] Step bits turn increment into decrement
// [RULE20] Toggle bit flips select on pointer use
// [RULE21] Pointer zero bytes and pointer one low
// [RULE22] Pointer one high byte register
// [RULE23] Reset sources synchronised, released on edge
// [RULE24] Down-counter stalls fetch for wait states
module cpu_core_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Special function register access
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire cpu_ctrl_pkg::byte_t sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic ta_unlocked_i,
    output cpu_ctrl_pkg::byte_t sfr_rdata_o,
    // Reset sources and pin
    input wire logic por_i,
    input wire logic external_reset_pin_n_i,
    output logic external_reset_pin_n_o,
    output logic external_reset_pin_n_oe_o,
    input wire logic low_voltage_reset_i,
    input wire logic supply_drop_detector_i,
    input wire logic watchdog_reset_i,
    output logic core_rst_o,
    output logic watchdog_counter_en_o,
    // Program counter load
    output logic pc_load_o,
    output logic [19:0] pc_load_addr_o,
    // Clock control
    input wire logic clk_ext_req_i,
    input wire logic stop_mode_i,
    input wire logic sleep_mode_i,
    output logic clk_internal_sel_o,
    output logic internal_oscillator_en_o,
    // Address mode and stack
    input wire cpu_ctrl_pkg::byte_t stack_ptr_high_ext_i,
    input wire cpu_ctrl_pkg::byte_t stack_ptr_low_i,
    output logic wide_mode_o,
    output logic ext_stack_indicator_o,
    output cpu_ctrl_pkg::word_t stack_addr_o,
    // External moves
    input wire logic ext_mem_move_ri_i,
    input wire cpu_ctrl_pkg::byte_t ri_low_i,
    input wire cpu_ctrl_pkg::byte_t port_two_latch_i,
    input wire cpu_ctrl_pkg::byte_t ri_page_register_i,
    output cpu_ctrl_pkg::word_t ext_mem_addr_o,
    // Flash fetch
    input wire logic fetch_req_i,
    output logic fetch_stall_o,
    output logic fetch_done_o,
    // Data pointer operations
    input wire logic ptr_inc_i,
    input wire logic ptr_used_i,
    output cpu_ctrl_pkg::word_t data_ptr_o
);
    import cpu_ctrl_pkg::*;

    logic rst_all, wdt_rst_gated, pin_drive, rst_d;
    word_t data_ptr_zero, data_ptr_one, next_ptr0, next_ptr1;
    logic ptr_sel, next_sel, ptr_toggle_enable, next_tsl;
    logic [1:0] ptr_step_direction, next_step;
    logic [3:0] wait_states, next_wait;
    logic ri_page_source_sel, next_page_src;
    logic [1:0] addr_mode_sel, next_mode;
    logic supply_drop_en, next_sdrop_en;
    logic wdt_en, next_wdt_en, wdt_rst_en, next_wdt_rst_en;
    byte_t next_rdata;
    word_t next_ext_addr, next_stack_addr;
    logic wr_sel, wr_mode, ext_stack;

    function automatic word_t ptr_step(input word_t ptr, input logic dec);
        ptr_step = dec ? ptr - 16'h0001 : ptr + 16'h0001;
    endfunction : ptr_step

    function automatic logic sfr_write(input logic [7:0] ofs);
        sfr_write = sfr_wr_i && (sfr_addr_i == ofs);
    endfunction : sfr_write

    // [RULE6] Watchdog reset needs both enables
    assign wdt_rst_gated = watchdog_reset_i & wdt_en & wdt_rst_en;
    // Registers see the raw reset at once, not a cycle late
    assign rst_all = rst_i | core_rst_o;
    // Open drain: only ever pulls low
    assign external_reset_pin_n_o = 1'b0;
    assign external_reset_pin_n_oe_o = pin_drive;
    // [RULE12] Wide mode implies extended stack
    assign ext_stack = addr_mode_sel[1];
    assign wr_sel = sfr_wr_i && (sfr_addr_i == `CFG_OFS_PTR_SEL);
    assign wr_mode = sfr_wr_i && (sfr_addr_i == `CFG_OFS_MODE);

    reset_ctrl u_reset_ctrl (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .por_i(por_i),
        .external_reset_pin_n_i(external_reset_pin_n_i),
        .low_voltage_reset_i(low_voltage_reset_i),
        .supply_drop_detector_i(supply_drop_detector_i),
        .supply_drop_en_i(supply_drop_en),
        .watchdog_reset_i(wdt_rst_gated),
        .core_rst_o(core_rst_o),
        .pin_drive_o(pin_drive)
    );

    // [RULE24] Fetch stall counter
    flash_wait u_flash_wait (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_all),
        .fetch_req_i(fetch_req_i),
        .wait_states_i(wait_states),
        .fetch_stall_o(fetch_stall_o),
        .fetch_done_o(fetch_done_o)
    );

    always_comb begin
        next_ptr0 = data_ptr_zero;
        next_ptr1 = data_ptr_one;
        // [RULE19] Step direction per pointer
        if (ptr_inc_i && !ptr_sel) begin
            next_ptr0 = ptr_step(data_ptr_zero, ptr_step_direction[0]);
        end
        if (ptr_inc_i && ptr_sel) begin
            next_ptr1 = ptr_step(data_ptr_one, ptr_step_direction[1]);
        end
        // [RULE21] [RULE22] Byte writes win over stepping
        if (sfr_write(`CFG_OFS_PTR0_LO)) begin
            next_ptr0[7:0] = sfr_wdata_i;
        end
        if (sfr_write(`CFG_OFS_PTR0_HI)) begin
            next_ptr0[15:8] = sfr_wdata_i;
        end
        if (sfr_write(`CFG_OFS_PTR1_LO)) begin
            next_ptr1[7:0] = sfr_wdata_i;
        end
        if (sfr_write(`CFG_OFS_PTR1_HI)) begin
            next_ptr1[15:8] = sfr_wdata_i;
        end
        next_tsl = ptr_toggle_enable;
        next_step = ptr_step_direction;
        next_sel = ptr_sel;
        if (wr_sel) begin
            next_sel = sfr_wdata_i[`CFG_SEL_BIT];
            next_tsl = sfr_wdata_i[`CFG_TSL_BIT];
            next_step = sfr_wdata_i[`CFG_STEP_HI_BIT:`CFG_STEP_LO_BIT];
        end else if (ptr_used_i && ptr_toggle_enable) begin
            // [RULE20] Toggle on pointer use
            next_sel = ~ptr_sel;
        end
        next_wait = wait_states;
        if (sfr_write(`CFG_OFS_WAIT)) begin
            next_wait = sfr_wdata_i[3:0];
        end
        next_page_src = ri_page_source_sel;
        next_mode = addr_mode_sel;
        // [RULE14] Timed-access gate
        if (wr_mode && ta_unlocked_i) begin
            next_page_src = sfr_wdata_i[`CFG_PAGE_SRC_BIT];
            next_mode = sfr_wdata_i[1:0];
        end
        next_sdrop_en = supply_drop_en;
        next_wdt_en = wdt_en;
        next_wdt_rst_en = wdt_rst_en;
        if (sfr_write(`CFG_OFS_RST_CTRL)) begin
            next_sdrop_en = sfr_wdata_i[`CFG_SDROP_EN_BIT];
            next_wdt_en = sfr_wdata_i[`CFG_WDT_EN_BIT];
            next_wdt_rst_en = sfr_wdata_i[`CFG_WDT_RST_EN_BIT];
        end
    end

    // Read mux; data held between reads
    always_comb begin
        next_rdata = sfr_rdata_o;
        if (sfr_rd_i) begin
            if (sfr_addr_i == `CFG_OFS_PTR0_LO) begin
                next_rdata = data_ptr_zero[7:0];
            end else if (sfr_addr_i == `CFG_OFS_PTR0_HI) begin
                next_rdata = data_ptr_zero[15:8];
            end else if (sfr_addr_i == `CFG_OFS_PTR1_LO) begin
                next_rdata = data_ptr_one[7:0];
            end else if (sfr_addr_i == `CFG_OFS_PTR1_HI) begin
                next_rdata = data_ptr_one[15:8];
            end else if (sfr_addr_i == `CFG_OFS_PTR_SEL) begin
                // [RULE18] Current selection readable
                next_rdata = {ptr_step_direction, ptr_toggle_enable, 4'h0, ptr_sel};
            end else if (sfr_addr_i == `CFG_OFS_WAIT) begin
                next_rdata = {4'h0, wait_states};
            end else if (sfr_addr_i == `CFG_OFS_MODE) begin
                next_rdata = {4'h0, ri_page_source_sel, ext_stack, addr_mode_sel};
            end else if (sfr_addr_i == `CFG_OFS_RST_CTRL) begin
                next_rdata = {5'h00, wdt_rst_en, wdt_en, supply_drop_en};
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // Address formation
    always_comb begin
        // [RULE13] High byte source for indirect moves
        // [RULE11] Data address stays sixteen bits
        if (ext_mem_move_ri_i) begin
            next_ext_addr = {ri_page_source_sel ? ri_page_register_i : port_two_latch_i,
                             ri_low_i};
        end else begin
            next_ext_addr = ptr_sel ? data_ptr_one : data_ptr_zero;
        end
        // [RULE12] Stack width follows mode
        if (ext_stack) begin
            next_stack_addr = {stack_ptr_high_ext_i, stack_ptr_low_i};
        end else begin
            next_stack_addr = {8'h00, stack_ptr_low_i};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        // [RULE1] Every register returns to default
        if (rst_all) begin
            data_ptr_zero <= 16'h0000;
            data_ptr_one <= 16'h0000;
            ptr_sel <= 1'b0;
            ptr_toggle_enable <= 1'b0;
            ptr_step_direction <= 2'h0;
            // [RULE16] Eight cycles per fetch
            wait_states <= `CFG_WAIT_RST;
            ri_page_source_sel <= 1'b0;
            addr_mode_sel <= 2'h0;
            // [RULE2] [RULE6] Enables cleared
            supply_drop_en <= 1'b0;
            wdt_en <= 1'b0;
            wdt_rst_en <= 1'b0;
            sfr_rdata_o <= 8'h00;
            rst_d <= 1'b1;
            pc_load_o <= 1'b0;
            pc_load_addr_o <= `CFG_PC_VECTOR;
            // [RULE8] Internal oscillator after reset
            clk_internal_sel_o <= 1'b1;
            internal_oscillator_en_o <= 1'b1;
            wide_mode_o <= 1'b0;
            ext_stack_indicator_o <= 1'b0;
            stack_addr_o <= 16'h0000;
            ext_mem_addr_o <= 16'h0000;
            data_ptr_o <= 16'h0000;
            watchdog_counter_en_o <= 1'b0;
        end else begin
            data_ptr_zero <= next_ptr0;
            data_ptr_one <= next_ptr1;
            ptr_sel <= next_sel;
            ptr_toggle_enable <= next_tsl;
            ptr_step_direction <= next_step;
            wait_states <= next_wait;
            ri_page_source_sel <= next_page_src;
            addr_mode_sel <= next_mode;
            supply_drop_en <= next_sdrop_en;
            wdt_en <= next_wdt_en;
            wdt_rst_en <= next_wdt_rst_en;
            sfr_rdata_o <= next_rdata;
            rst_d <= 1'b0;
            // [RULE7] Vector load on release
            pc_load_o <= rst_d;
            pc_load_addr_o <= `CFG_PC_VECTOR;
            clk_internal_sel_o <= ~clk_ext_req_i;
            // [RULE9] Oscillator off in stop or sleep
            internal_oscillator_en_o <= ~(stop_mode_i | sleep_mode_i);
            // [RULE10] Upper mode bit selects wide
            wide_mode_o <= addr_mode_sel[1];
            ext_stack_indicator_o <= ext_stack;
            stack_addr_o <= next_stack_addr;
            ext_mem_addr_o <= next_ext_addr;
            data_ptr_o <= next_sel ? next_ptr1 : next_ptr0;
            watchdog_counter_en_o <= wdt_en;
        end
    end

    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_all);

    a_wait_reset_val: // [RULE16]
    assert property ($past(rst_all) |-> wait_states == 4'h7)
        else $error("wait states not seven after reset");

    a_pc_vector_load: // [RULE7]
    assert property ($fell(core_rst_o)
        |=> pc_load_o && pc_load_addr_o == 20'h0F000)
        else $error("vector not loaded at reset release");

    a_mode_locked: // [RULE14]
    assert property (wr_mode && !ta_unlocked_i
        |=> addr_mode_sel == $past(addr_mode_sel)
            && ri_page_source_sel == $past(ri_page_source_sel))
        else $error("mode register written while locked");

    a_sel_toggle: // [RULE20]
    assert property (ptr_used_i && ptr_toggle_enable && !wr_sel
        |=> ptr_sel != $past(ptr_sel))
        else $error("select did not toggle");

    a_ptr0_decrement: // [RULE19]
    assert property (ptr_inc_i && !ptr_sel && ptr_step_direction[0] && !sfr_wr_i
        |=> data_ptr_zero == $past(data_ptr_zero) - 16'h0001)
        else $error("pointer zero not decremented");

    a_page_source: // [RULE13]
    assert property (ext_mem_move_ri_i && ri_page_source_sel
        |=> ext_mem_addr_o[15:8] == $past(ri_page_register_i))
        else $error("page register not used");

    a_narrow_stack: // [RULE12]
    assert property (!addr_mode_sel[1] |=> stack_addr_o[15:8] == 8'h00
        && !ext_stack_indicator_o)
        else $error("stack high byte used in narrow mode");

    a_osc_stopped: // [RULE9]
    assert property ((stop_mode_i || sleep_mode_i) ##1 !rst_all
        |-> !internal_oscillator_en_o)
        else $error("oscillator left on in stop or sleep");

    a_fetch_eight: // [RULE15]
    assert property (fetch_req_i && !fetch_stall_o && wait_states == 4'h7
        |=> !fetch_done_o [*8] ##1 fetch_done_o)
        else $error("fetch not done after eight cycles");
endmodule : cpu_core_ctrl

// >>> verification/reset_pin_model.sv
// Far side of the reset pin: pull-up, push button and the chip's pull-down
`timescale 1ns/1ps
module reset_pin_model (
    // Chip drive and button
    input wire logic pull_low_i,
    input wire logic drive_en_i,
    input wire logic button_n_i,
    // Level seen on the pin
    output logic pin_level_o
);
    // Button holds pin low while pressed
    // Pull-up wins only when nobody pulls low
    assign pin_level_o = !((drive_en_i && !pull_low_i) || !button_n_i);
endmodule : reset_pin_model

// >>> verification/tb_top.sv
// Self-checking bench of the core control block
`timescale 1ns/1ps
module tb_top;
    import cpu_ctrl_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    byte_t sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic ta_unlocked_i = 1'b0, por_i = 1'b0, low_voltage_reset_i = 1'b0;
    logic supply_drop_detector_i = 1'b0, watchdog_reset_i = 1'b0, button_n = 1'b1;
    logic external_reset_pin_n_i, external_reset_pin_n_o, external_reset_pin_n_oe_o;
    logic core_rst_o, watchdog_counter_en_o, pc_load_o, clk_internal_sel_o;
    logic [19:0] pc_load_addr_o;
    logic clk_ext_req_i = 1'b0, stop_mode_i = 1'b0, sleep_mode_i = 1'b0;
    logic internal_oscillator_en_o, wide_mode_o, ext_stack_indicator_o;
    byte_t stack_ptr_high_ext_i = 8'h00, stack_ptr_low_i = 8'h00, ri_low_i = 8'h00;
    byte_t port_two_latch_i = 8'h00, ri_page_register_i = 8'h00;
    word_t stack_addr_o, ext_mem_addr_o, data_ptr_o;
    logic ext_mem_move_ri_i = 1'b0, fetch_req_i = 1'b0, fetch_stall_o, fetch_done_o;
    logic ptr_inc_i = 1'b0, ptr_used_i = 1'b0, rd_seen = 1'b0;
    int seed = 32'h3ced;
    int fails = 0;
    int checked = 0;
    byte_t expq [$];
    word_t p [2];

    cpu_core_ctrl dut (.clk_sys_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
        .ta_unlocked_i, .sfr_rdata_o, .por_i, .external_reset_pin_n_i,
        .external_reset_pin_n_o, .external_reset_pin_n_oe_o, .low_voltage_reset_i,
        .supply_drop_detector_i, .watchdog_reset_i, .core_rst_o, .watchdog_counter_en_o,
        .pc_load_o, .pc_load_addr_o, .clk_ext_req_i, .stop_mode_i, .sleep_mode_i,
        .clk_internal_sel_o, .internal_oscillator_en_o, .stack_ptr_high_ext_i,
        .stack_ptr_low_i, .wide_mode_o, .ext_stack_indicator_o, .stack_addr_o,
        .ext_mem_move_ri_i, .ri_low_i, .port_two_latch_i, .ri_page_register_i,
        .ext_mem_addr_o, .fetch_req_i, .fetch_stall_o, .fetch_done_o, .ptr_inc_i,
        .ptr_used_i, .data_ptr_o);

    reset_pin_model pin (.pull_low_i(external_reset_pin_n_o),
        .drive_en_i(external_reset_pin_n_oe_o), .button_n_i(button_n),
        .pin_level_o(external_reset_pin_n_i));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input byte_t d);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_wr_i = 1'b0;
    endtask : wr

    // Expectation queued; the watcher below pops it when data lands
    task automatic rd(input logic [7:0] a, input byte_t e);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        expq.push_back(e);
        @(negedge clk_sys_i);
        sfr_rd_i = 1'b0;
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge clk_sys_i);
        s = 1'b1;
        @(negedge clk_sys_i);
        s = 1'b0;
    endtask : pulse

    // Bounded wait, then defaults must be back
    task automatic released;
        int k;
        k = 0;
        while (core_rst_o !== 1'b0 && k < 100) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk(20'(core_rst_o), 20'h0);
        cyc(1);
        chk(20'(pc_load_o), 20'h1);
        cyc(1);
        chk(pc_load_addr_o, 20'h0F000);
        chk(20'(clk_internal_sel_o), 20'h1);
        chk(20'(watchdog_counter_en_o), 20'h0);
        rd(8'h92, 8'h07);
        rd(8'h86, 8'h00);
        rd(8'h9E, 8'h00);
        rd(8'h9D, 8'h00);
    endtask : released

    // Source raised until reset shows, bounded, then released
    task automatic hit(ref logic s);
        int k;
        k = 0;
        s = 1'b1;
        while (core_rst_o !== 1'b1 && k < 20) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk(20'(core_rst_o), 20'h1);
        s = 1'b0;
        released();
    endtask : hit

    always @(posedge clk_sys_i) rd_seen <= sfr_rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_seen === 1'b1) begin
            chk(20'(sfr_rdata_o), 20'(expq.pop_front()));
        end
    end

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        logic [3:0] w;
        logic [1:0] id;
        logic sel;
        byte_t b;
        int n;
        cyc(8);
        rst_i = 1'b0;
        released();
        rd(8'h80, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b = byte_t'($random(seed));
            p[i / 2][(i % 2) * 8 +: 8] = b;
            wr(8'(8'h82 + i), b);
            rd(8'(8'h82 + i), b);
        end
        $display("test registers done");
        ri_low_i = byte_t'($random(seed));
        port_two_latch_i = byte_t'($random(seed));
        ri_page_register_i = byte_t'($random(seed));
        stack_ptr_low_i = byte_t'($random(seed));
        stack_ptr_high_ext_i = byte_t'($random(seed));
        ext_mem_move_ri_i = 1'b1;
        wr(8'h9D, 8'h0A);
        rd(8'h9D, 8'h00);
        ta_unlocked_i = 1'b1;
        wr(8'h9D, 8'h0A);
        rd(8'h9D, 8'h0E);
        chk(20'({wide_mode_o, ext_stack_indicator_o}), 20'h3);
        chk(20'(ext_mem_addr_o), 20'({ri_page_register_i, ri_low_i}));
        chk(20'(stack_addr_o), 20'({stack_ptr_high_ext_i, stack_ptr_low_i}));
        wr(8'h9D, 8'h01);
        rd(8'h9D, 8'h01);
        chk(20'({wide_mode_o, ext_stack_indicator_o}), 20'h0);
        chk(20'(ext_mem_addr_o), 20'({port_two_latch_i, ri_low_i}));
        chk(20'(stack_addr_o), 20'({8'h00, stack_ptr_low_i}));
        ta_unlocked_i = 1'b0;
        $display("test address mode done");
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 4'h0 : (i == 1) ? 4'(($random(seed))) : (i == 2) ? 4'hF : 4'h7;
            wr(8'h92, {4'h0, w});
            @(negedge clk_sys_i);
            fetch_req_i = 1'b1;
            n = 0;
            do begin
                @(negedge clk_sys_i);
                fetch_req_i = 1'b0;
                n++;
                if (n == 1) begin
                    chk(20'(fetch_stall_o), 20'h1);
                end
            end while (fetch_done_o !== 1'b1 && n < 40);
            chk(20'(n), 20'(w) + 20'h2);
        end
        $display("test wait states done");
        for (int c = 0; c < 8; c++) begin
            sel = c[0];
            id = 2'(c >> 1);
            wr(8'h86, {id, 5'h00, sel});
            pulse(ptr_inc_i);
            p[sel] = (sel ? id[1] : id[0]) ? p[sel] - 16'h1 : p[sel] + 16'h1;
            chk(20'(data_ptr_o), 20'(p[sel]));
        end
        wr(8'h86, 8'h20);
        pulse(ptr_used_i);
        rd(8'h86, 8'h21);
        chk(20'(data_ptr_o), 20'(p[1]));
        pulse(ptr_used_i);
        rd(8'h86, 8'h20);
        $display("test pointers done");
        for (int i = 0; i < 3; i++) begin
            {stop_mode_i, sleep_mode_i} = 2'(i);
            cyc(3);
            chk(20'(internal_oscillator_en_o), 20'(i == 0));
        end
        {stop_mode_i, sleep_mode_i} = 2'b00;
        supply_drop_detector_i = 1'b1;
        watchdog_reset_i = 1'b1;
        cyc(20);
        chk(20'(core_rst_o), 20'h0);
        supply_drop_detector_i = 1'b0;
        watchdog_reset_i = 1'b0;
        // Let the synchronised level clear before enabling
        cyc(5);
        wr(8'h9E, 8'h01);
        hit(supply_drop_detector_i);
        wr(8'h9E, 8'h06);
        cyc(1);
        chk(20'(watchdog_counter_en_o), 20'h1);
        hit(watchdog_reset_i);
        low_voltage_reset_i = 1'b1;
        cyc(10);
        chk(20'({core_rst_o, external_reset_pin_n_oe_o}), 20'h3);
        low_voltage_reset_i = 1'b0;
        released();
        por_i = 1'b1;
        cyc(10);
        chk(20'(core_rst_o), 20'h1);
        por_i = 1'b0;
        released();
        button_n = 1'b0;
        cyc(1000);
        button_n = 1'b1;
        cyc(10);
        chk(20'(core_rst_o), 20'h0);
        button_n = 1'b0;
        cyc(12500);
        chk(20'(core_rst_o), 20'h1);
        button_n = 1'b1;
        released();
        $display("test reset sources done");
        results();
    end
endmodule : tb_top
